// ### verilog/dbgisp_defs.vh
// Purpose: Shared constants of the debug and programming entry control
// Assumes: Included by the design files of this block only
// Notes: Clock source codes follow the clock-select fuse field
`ifndef DBGISP_DEFS_VH
`define DBGISP_DEFS_VH

// ==========================================================
// Clock source fuse codes
`define DBGISP_CLK_CRYSTAL 2'h0
`define DBGISP_CLK_EXTERNAL 2'h1
`define DBGISP_CLK_RC 2'h2

// ==========================================================
// Fuse levels
`define DBGISP_FUSE_PROGRAMMED 1'h0

// ==========================================================
// Timing
`define DBGISP_REF_CLK_HZ 50000000
`define DBGISP_BRK_NOP_CYCLES 2'h2
`define DBGISP_SPI_MAX_HZ 5000000
`define DBGISP_SPI_MIN_HALF_CYC ((`DBGISP_REF_CLK_HZ + 2 * `DBGISP_SPI_MAX_HZ - 1) / (2 * `DBGISP_SPI_MAX_HZ))

// ==========================================================
// Serial byte layout and pin synchroniser width
`define DBGISP_BYTE_W 8
`define DBGISP_BIT_LAST 3'h7
`define DBGISP_SYNC_W 6

`endif

// ### verilog/dbgisp_sync2.v
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to ref_clk
// Notes: First stage feeds only the second stage
`default_nettype none

module dbgisp_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // ==========================================================
  // Per-bit stages
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ### verilog/dbgisp_ctrl.v
// Purpose: Debug pin assignment, break handling and serial programming entry
// Assumes: Fuse levels are static while running; por_active is on ref_clk
// Notes: Debug and SPI clocks are pins sampled by ref_clk, no second domain
`include "dbgisp_defs.vh"
`default_nettype none

module dbgisp_ctrl (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Configuration fuses and power-on reset
  input wire fuse_debug_en_n,
  input wire fuse_fast_debug,
  input wire [1:0] fuse_clk_src,
  input wire fuse_reset_disable,
  input wire fuse_isp_en,
  input wire por_active,
  // Reset and shared port pin
  input wire reset_shared_port_pin,
  // Oscillator pins
  input wire oscillator_pin_a_in,
  output wire oscillator_pin_a_out,
  output wire oscillator_pin_a_oe,
  input wire oscillator_pin_b_in,
  output wire oscillator_pin_b_out,
  output wire oscillator_pin_b_oe,
  // Debug core side
  input wire debug_tx_data,
  input wire debug_tx_en,
  output reg on_chip_debug,
  output reg normal_two_wire_debug,
  output reg fast_two_wire_debug,
  output reg debug_serial_clock,
  output reg debug_clk_rise,
  output reg debug_clk_fall,
  output reg debug_serial_data,
  // Clock and pin function control
  output reg [1:0] clk_src_eff,
  output reg sysclk_on_osc_a,
  output reg port_pin_avail,
  output reg ext_reset_req,
  output reg ext_int_a_avail,
  output reg external_interrupt_b_avail,
  output reg system_clock_output_avail,
  // Break instruction
  input wire brk_exec,
  output wire brk_stall,
  output reg brk_done,
  output reg debug_break_req,
  // Watchdog
  input wire wdt_overflow,
  input wire wdt_break_en,
  input wire debug_reset_cmd,
  output reg wdt_reset_req,
  output reg wdt_state_clear,
  // Serial programming pins
  input wire spi_sck,
  input wire spi_mosi,
  input wire spi_ss_n,
  output wire spi_miso,
  output wire spi_miso_oe,
  // Programming engine side
  input wire [7:0] isp_tx_byte,
  output reg isp_active,
  output reg [7:0] isp_rx_byte,
  output reg isp_rx_valid,
  output reg isp_frame_end,
  output reg isp_locked
);

  // ==========================================================
  // Pin synchronisers
  // Active-low pins enter inverted so a flushed synchroniser reads them idle
  wire [`DBGISP_SYNC_W-1:0] pins_raw = {
    ~reset_shared_port_pin,
    oscillator_pin_a_in,
    oscillator_pin_b_in,
    spi_sck,
    spi_mosi,
    ~spi_ss_n
  };
  wire [`DBGISP_SYNC_W-1:0] pins_s;
  dbgisp_sync2 #(
    .WIDTH(`DBGISP_SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );
  wire rst_pin_s = ~pins_s[5];
  wire osc_a_s = pins_s[4];
  wire osc_b_s = pins_s[3];
  wire sck_s = pins_s[2];
  wire mosi_s = pins_s[1];
  wire ss_n_s = ~pins_s[0];

  // ==========================================================
  // Fuse decode
  // Fuses are static levels, read without a synchroniser
  wire ocd_d = (fuse_debug_en_n == `DBGISP_FUSE_PROGRAMMED);
  wire [1:0] src_d = (ocd_d && fuse_clk_src == `DBGISP_CLK_CRYSTAL) ? `DBGISP_CLK_EXTERNAL : fuse_clk_src;
  wire rc_d = (src_d == `DBGISP_CLK_RC);
  // Crystal cannot stay: its pins carry debug data
  wire dda_on_b_d = ocd_d && !rc_d;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      on_chip_debug <= 1'b0;
      normal_two_wire_debug <= 1'b0;
      fast_two_wire_debug <= 1'b0;
      clk_src_eff <= `DBGISP_CLK_CRYSTAL;
      sysclk_on_osc_a <= 1'b0;
      port_pin_avail <= 1'b0;
      ext_int_a_avail <= 1'b0;
      external_interrupt_b_avail <= 1'b0;
      system_clock_output_avail <= 1'b0;
    end else begin
      on_chip_debug <= ocd_d;
      normal_two_wire_debug <= ocd_d && !fuse_fast_debug;
      fast_two_wire_debug <= ocd_d && fuse_fast_debug;
      clk_src_eff <= src_d;
      sysclk_on_osc_a <= ocd_d && !rc_d;
      port_pin_avail <= !ocd_d && fuse_reset_disable;
      ext_int_a_avail <= !ocd_d;
      external_interrupt_b_avail <= !(ocd_d && !rc_d);
      system_clock_output_avail <= !(ocd_d && !rc_d);
    end
  end

  // ==========================================================
  // Debug clock and data pins
  // Pulses trail the pin by the two sync stages plus one
  reg dcl_prev_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // Pin idles high, so the edge history starts high
      dcl_prev_q <= 1'b1;
      debug_serial_clock <= 1'b0;
      debug_clk_rise <= 1'b0;
      debug_clk_fall <= 1'b0;
      debug_serial_data <= 1'b0;
    end else begin
      dcl_prev_q <= rst_pin_s;
      debug_serial_clock <= on_chip_debug && rst_pin_s;
      debug_clk_rise <= on_chip_debug && rst_pin_s && !dcl_prev_q;
      debug_clk_fall <= on_chip_debug && !rst_pin_s && dcl_prev_q;
      debug_serial_data <= on_chip_debug && (dda_on_b_d ? osc_b_s : osc_a_s);
    end
  end

  // Drive only while the debug core answers
  wire dda_drive = on_chip_debug && debug_tx_en;
  // Index 0 is pin a, index 1 is pin b
  wire [1:0] dda_pin_sel = {dda_on_b_d, ~dda_on_b_d};
  wire [1:0] osc_oe;
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_osc_pin
      assign osc_oe[p] = dda_drive && dda_pin_sel[p];
    end
  endgenerate
  assign oscillator_pin_a_oe = osc_oe[0];
  assign oscillator_pin_b_oe = osc_oe[1];
  assign oscillator_pin_b_out = debug_tx_data;
  assign oscillator_pin_a_out = debug_tx_data;

  // ==========================================================
  // Break instruction
  // A break inside the count is ignored; the core spaces them
  reg [1:0] brk_cnt_q;
  assign brk_stall = brk_exec && !on_chip_debug && (brk_cnt_q == 2'h0);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      brk_cnt_q <= 2'h0;
      brk_done <= 1'b0;
      debug_break_req <= 1'b0;
    end else begin
      brk_done <= 1'b0;
      debug_break_req <= 1'b0;
      if (brk_cnt_q != 2'h0) begin
        brk_cnt_q <= brk_cnt_q - 2'h1;
        brk_done <= (brk_cnt_q == 2'h1);
      end else if (brk_exec && !on_chip_debug) begin
        brk_cnt_q <= `DBGISP_BRK_NOP_CYCLES - 2'h1;
      end
      if (brk_exec && on_chip_debug) begin
        debug_break_req <= 1'b1;
      end
      if (wdt_overflow && on_chip_debug && wdt_break_en) begin
        debug_break_req <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Watchdog side effects
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdt_reset_req <= 1'b0;
      wdt_state_clear <= 1'b0;
    end else begin
      // Break path keeps watchdog state; only a debug reset clears it
      wdt_reset_req <= wdt_overflow && !(on_chip_debug && wdt_break_en);
      wdt_state_clear <= (wdt_overflow && !(on_chip_debug && wdt_break_en)) ||
                         (on_chip_debug && debug_reset_cmd);
    end
  end

  // ==========================================================
  // Programming mode entry
  localparam ST_IDLE = 3'h1;
  localparam ST_ACTIVE = 3'h2;
  localparam ST_LOCKED = 3'h4;
  reg [2:0] st_q;
  reg [2:0] st_d;
  wire rst_low = !rst_pin_s;
  // External reset period needs an enabled reset pin and no debug
  wire ext_reset_period = rst_low && !fuse_reset_disable && !ocd_d;
  wire entry_ok = rst_low && (por_active || (fuse_isp_en && ext_reset_period));

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (entry_ok) begin
          st_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!rst_low) begin
          st_d = fuse_reset_disable ? ST_LOCKED : ST_IDLE;
        end
      end
      // Only power-on reset, taken as a power cycle, frees the lock
      ST_LOCKED: begin
        if (por_active) begin
          st_d = entry_ok ? ST_ACTIVE : ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      isp_active <= 1'b0;
      isp_locked <= 1'b0;
      ext_reset_req <= 1'b0;
    end else begin
      st_q <= st_d;
      isp_active <= (st_d == ST_ACTIVE);
      isp_locked <= (st_d == ST_LOCKED);
      ext_reset_req <= ext_reset_period || (rst_low && por_active);
    end
  end

  // ==========================================================
  // SPI slave, mode 0, clocked by sampled programmer clock
  // Half a serial clock must span three ref_clk or edges are lost
  reg sck_prev_q;
  reg ss_prev_q;
  reg [2:0] bit_q;
  reg [7:0] rx_sh_q;
  reg [7:0] tx_sh_q;
  wire in_frame = isp_active && !ss_n_s;
  wire sck_rise = sck_s && !sck_prev_q;
  wire sck_fall = !sck_s && sck_prev_q;
  wire frame_start = in_frame && ss_prev_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
      bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      isp_rx_byte <= 8'h00;
      isp_rx_valid <= 1'b0;
      isp_frame_end <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      ss_prev_q <= ss_n_s;
      isp_rx_valid <= 1'b0;
      isp_frame_end <= isp_active && ss_n_s && !ss_prev_q;
      if (!in_frame) begin
        bit_q <= 3'h0;
      end else if (frame_start) begin
        bit_q <= 3'h0;
        tx_sh_q <= isp_tx_byte;
      end else if (sck_rise) begin
        // Mode 0: sample on rising edge
        rx_sh_q <= {rx_sh_q[6:0], mosi_s};
        bit_q <= bit_q + 3'h1;
        if (bit_q == `DBGISP_BIT_LAST) begin
          isp_rx_byte <= {rx_sh_q[6:0], mosi_s};
          isp_rx_valid <= 1'b1;
        end
      end else if (sck_fall) begin
        // Mode 0: shift out on falling edge
        if (bit_q == 3'h0) begin
          tx_sh_q <= isp_tx_byte;
        end else begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // Slave only: output driven while selected in programming mode
  assign spi_miso_oe = in_frame;
  assign spi_miso = tx_sh_q[7];

endmodule

`default_nettype wire

// ### testbench/dbgisp_ctrl_monitor.sv
// Purpose: Port-level checker for debug pin control and programming entry
// Assumes: Single ref_clk domain, resetn asynchronous active low
// Notes: Pin inputs pass two sync flops, so pin-driven relations allow for that lag
`default_nettype none

module dbgisp_ctrl_monitor (
  // Clock, reset, fuses
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic fuse_debug_en_n,
  input wire logic fuse_fast_debug,
  input wire logic [1:0] fuse_clk_src,
  input wire logic fuse_reset_disable,
  input wire logic fuse_isp_en,
  input wire logic por_active,
  input wire logic reset_shared_port_pin,
  // Debug side
  input wire logic debug_tx_en,
  input wire logic on_chip_debug,
  input wire logic normal_two_wire_debug,
  input wire logic fast_two_wire_debug,
  input wire logic [1:0] clk_src_eff,
  input wire logic port_pin_avail,
  input wire logic ext_reset_req,
  input wire logic oscillator_pin_a_oe,
  input wire logic oscillator_pin_b_oe,
  // Break and watchdog
  input wire logic brk_exec,
  input wire logic brk_stall,
  input wire logic brk_done,
  input wire logic debug_break_req,
  input wire logic wdt_overflow,
  input wire logic wdt_break_en,
  input wire logic wdt_reset_req,
  input wire logic wdt_state_clear,
  // Programming
  input wire logic isp_active,
  input wire logic isp_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Debug configuration
  debug_enable_a: assert property ($past(resetn) |-> on_chip_debug == !$past(fuse_debug_en_n))
    else $error("Debug enable does not follow fuse");
  protocol_select_a: assert property ($past(resetn) |->
    {fast_two_wire_debug, normal_two_wire_debug} == ({2{on_chip_debug}} & {$past(fuse_fast_debug), !$past(fuse_fast_debug)}))
    else $error("Protocol select wrong");
  crystal_fallback_a: assert property ($past(resetn) && on_chip_debug && $past(fuse_clk_src) == 2'h0 |-> clk_src_eff == 2'h1)
    else $error("Crystal not replaced by external clock");
  pin_loss_a: assert property (on_chip_debug && !por_active && !$past(por_active) |-> !port_pin_avail && !ext_reset_req)
    else $error("Clock pin still offers port or reset");
  data_drive_a: assert property (oscillator_pin_a_oe || oscillator_pin_b_oe |-> debug_tx_en && on_chip_debug &&
    oscillator_pin_a_oe != oscillator_pin_b_oe && oscillator_pin_a_oe == (clk_src_eff == 2'h2))
    else $error("Debug data driven on wrong pin or unasked");

  // ==========================================================
  // Break and watchdog
  break_nop_a: assert property (brk_exec && !on_chip_debug |-> brk_stall ##1 !debug_break_req ##1 brk_done)
    else $error("Break no-op timing wrong");
  wdt_break_a: assert property (wdt_overflow && wdt_break_en && on_chip_debug |=>
    debug_break_req && !wdt_state_clear && !wdt_reset_req) else $error("Watchdog break disturbed watchdog");

  // ==========================================================
  // Programming entry
  isp_hold_a: assert property (reset_shared_port_pin [*4] |-> !isp_active)
    else $error("Programming kept with reset pin high");
  isp_entry_a: assert property ($rose(isp_active) |-> $past(por_active) ||
    ($past(fuse_isp_en) && !$past(fuse_reset_disable) && $past(fuse_debug_en_n))) else $error("Programming entered illegally");
  isp_lock_a: assert property (isp_locked && !por_active |=> !isp_active)
    else $error("Second session accepted before power cycle");
endmodule

bind dbgisp_ctrl dbgisp_ctrl_monitor mon (.*);
`default_nettype wire

// ### testbench/dbgisp_prog_model.sv
// Purpose: Serial programmer acting as SPI master
// Assumes: Mode 0, serial clock period of 160 ns
// Notes: Clock idles low outside frames; select is always driven
`default_nettype none

module dbgisp_prog_model (
  // Serial lines
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_NS = 80;

  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end

  task frame(input logic on);
    ss_n = !on;
    #HALF_NS;
  endtask

  // Master drives clock and data, device only answers
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #HALF_NS sck = 1'b1;
      rx[i] = miso;
      #HALF_NS sck = 1'b0;
    end
    mosi = !mosi; // Released line must not show a stale bit
  endtask
endmodule
`default_nettype wire

// ### testbench/dbgisp_ctrl_test.sv
// Purpose: Directed test of debug pin control and programming entry
// Assumes: Fuses change only between scenarios
// Notes: Programmer pins come from the partner model
`default_nettype none

module dbgisp_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, resetn = 1'b0, fuse_debug_en_n = 1'b1, fuse_fast_debug = 1'b0;
  logic fuse_reset_disable = 1'b0, fuse_isp_en = 1'b0, por_active = 1'b0, reset_shared_port_pin = 1'b1;
  logic [1:0] fuse_clk_src = 2'h0, eff;
  logic osc_a_drv = 1'b0, osc_b_drv = 1'b0, debug_tx_data = 1'b1, debug_tx_en = 1'b0;
  logic brk_exec = 1'b0, wdt_overflow = 1'b0, wdt_break_en = 1'b0, debug_reset_cmd = 1'b0;
  logic [7:0] isp_tx_byte = 8'h5a, rx, last_rx = 8'h00;
  wire spi_sck, spi_mosi, spi_ss_n, spi_miso, spi_miso_oe, oscillator_pin_a_out, oscillator_pin_a_oe;
  wire oscillator_pin_b_out, oscillator_pin_b_oe, on_chip_debug, normal_two_wire_debug, fast_two_wire_debug;
  wire debug_serial_clock, debug_clk_rise, debug_clk_fall, debug_serial_data, sysclk_on_osc_a, port_pin_avail;
  wire ext_reset_req, ext_int_a_avail, external_interrupt_b_avail, system_clock_output_avail, brk_stall, brk_done;
  wire debug_break_req, wdt_reset_req, wdt_state_clear, isp_active, isp_rx_valid, isp_frame_end, isp_locked;
  wire [1:0] clk_src_eff;
  wire [7:0] isp_rx_byte;
  int err_count = 0;
  int check_count = 0;
  int frame_count = 0;
  // Pin level: device wins while it drives
  wire oscillator_pin_a_in = oscillator_pin_a_oe ? oscillator_pin_a_out : osc_a_drv;
  wire oscillator_pin_b_in = oscillator_pin_b_oe ? oscillator_pin_b_out : osc_b_drv;

  dbgisp_ctrl dut (.*);
  dbgisp_prog_model prog (.sck(spi_sck), .mosi(spi_mosi), .ss_n(spi_ss_n), .miso(spi_miso));

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (isp_rx_valid) last_rx <= isp_rx_byte;
  always @(posedge ref_clk) if (isp_frame_end) frame_count <= frame_count + 1;

  // ==========================================================
  // Shared tasks
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task close_out;
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run is about 5 us; some sixty times that means a hang
  initial begin
    #300us;
    err_count++;
    close_out;
  end

  // ==========================================================
  // Scenarios
  initial begin
    step(12);
    @(posedge ref_clk) resetn <= 1'b1;
    step(3);
    chk("debug_on", on_chip_debug, 1'b0);
    @(posedge ref_clk) brk_exec <= 1'b1;
    #1 chk("brk_stall", brk_stall, 1'b1);
    @(posedge ref_clk) brk_exec <= 1'b0;
    step(1);
    chk("brk_done", {brk_done, debug_break_req}, 2'h2);
    @(posedge ref_clk) wdt_overflow <= 1'b1;
    @(posedge ref_clk) wdt_overflow <= 1'b0;
    #1 chk("wdt_reset", {wdt_reset_req, wdt_state_clear}, 2'h3);
    @(posedge ref_clk) fuse_debug_en_n <= 1'b0;
    wdt_break_en <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk) fuse_clk_src <= s[1:0];
      fuse_fast_debug <= s[0];
      debug_tx_en <= 1'b0;
      osc_a_drv <= (s == 2);
      osc_b_drv <= (s != 2);
      step(4);
      eff = (s == 0) ? 2'h1 : s[1:0];
      chk("proto", {on_chip_debug, fast_two_wire_debug, normal_two_wire_debug}, {1'b1, s[0], !s[0]});
      chk("clk_src", clk_src_eff, eff);
      chk("pin_loss", {sysclk_on_osc_a, port_pin_avail, ext_reset_req, ext_int_a_avail, external_interrupt_b_avail,
        system_clock_output_avail}, {eff == 2'h1, 3'h0, eff == 2'h2, eff == 2'h2});
      chk("data_in", {debug_serial_data, oscillator_pin_a_oe, oscillator_pin_b_oe}, 3'h4);
      @(posedge ref_clk) debug_tx_en <= 1'b1;
      debug_tx_data <= s[0];
      #1 chk("data_oe", {oscillator_pin_a_oe, oscillator_pin_b_oe, oscillator_pin_a_out, oscillator_pin_b_out},
        {eff == 2'h2, eff != 2'h2, s[0], s[0]});
    end
    @(posedge ref_clk) wdt_overflow <= 1'b1;
    @(posedge ref_clk) wdt_overflow <= 1'b0;
    #1 chk("wdt_brk", {debug_break_req, wdt_reset_req, wdt_state_clear}, 3'h4);
    @(posedge ref_clk) debug_reset_cmd <= 1'b1;
    @(posedge ref_clk) debug_reset_cmd <= 1'b0;
    #1 chk("wdt_clr", wdt_state_clear, 1'b1);
    @(posedge ref_clk) resetn <= 1'b0;
    step(2);
    chk("reset_dbg", {on_chip_debug, wdt_state_clear}, 2'h0);
    @(posedge ref_clk) resetn <= 1'b1;
    step(3);
    chk("dbg_again", {on_chip_debug, debug_serial_clock, debug_clk_rise}, 3'h6);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) reset_shared_port_pin <= i[0];
      step(3);
      chk("dbg_clk", {debug_serial_clock, debug_clk_rise, debug_clk_fall, ext_reset_req, isp_active},
        {i[0], i[0], !i[0], 2'h0});
    end
    @(posedge ref_clk) fuse_debug_en_n <= 1'b1;
    fuse_reset_disable <= 1'b1;
    por_active <= 1'b1;
    reset_shared_port_pin <= 1'b0;
    step(5);
    @(posedge ref_clk) por_active <= 1'b0;
    step(5);
    chk("isp_por", isp_active, 1'b1);
    prog.frame(1'b1);
    chk("miso_oe", spi_miso_oe, 1'b1);
    prog.xfer(8'hac, rx);
    step(3);
    chk("rx0", {last_rx, rx}, {8'hac, 8'h5a});
    prog.xfer(8'h53, rx);
    step(3);
    chk("rx1", {last_rx, rx}, {8'h53, 8'h5a});
    prog.frame(1'b0);
    @(posedge ref_clk) reset_shared_port_pin <= 1'b1;
    step(4);
    chk("isp_end", {isp_active, isp_locked}, 2'h1);
    chk("frame_end", {spi_miso_oe, frame_count[6:0]}, 8'h01);
    @(posedge ref_clk) reset_shared_port_pin <= 1'b0;
    step(5);
    chk("isp_refuse", isp_active, 1'b0);
    @(posedge ref_clk) por_active <= 1'b1;
    step(2);
    @(posedge ref_clk) por_active <= 1'b0;
    step(3);
    chk("isp_repower", {isp_active, isp_locked}, 2'h2);
    @(posedge ref_clk) reset_shared_port_pin <= 1'b1;
    fuse_reset_disable <= 1'b0;
    for (int e = 1; e >= 0; e--) begin
      @(posedge ref_clk) fuse_isp_en <= e[0];
      reset_shared_port_pin <= 1'b0;
      step(5);
      chk("isp_any_reset", isp_active, e[0]);
      @(posedge ref_clk) reset_shared_port_pin <= 1'b1;
      step(4);
      chk("isp_off", {isp_active, isp_locked}, 2'h0);
    end
    close_out;
  end
endmodule
`default_nettype wire
